//--- hdl/vpc_pkg.sv
package vpc_pkg;
  // ==========================================
  // widths
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int WIDE_W = 32;
  localparam int NUM_RD = 3;
  // ==========================================
  // counter values
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] TIMER_LOAD = 16'h5000;
  localparam logic [31:0] WIDE_ZERO = 32'h0000_0000;
  localparam logic [31:0] WIDE_ONE = 32'h0000_0001;
  // ==========================================
  // read selects
  localparam logic [1:0] SEL_REV = 2'h0;
  localparam logic [1:0] SEL_WORK = 2'h1;
  localparam logic [1:0] SEL_TIMER = 2'h2;
  // ==========================================
  // timing
  localparam longint CLK_HZ = 125_000_000;
  localparam longint GATE_TIME_MS = 1000;
  localparam longint RATIO_TIME_US = 16667;
  localparam longint GATE_CYCLES_CALC = (CLK_HZ * GATE_TIME_MS) / 1000;
  localparam longint RATIO_CYCLES_CALC = (CLK_HZ * RATIO_TIME_US) / 1_000_000;
  // ==========================================
  // ratio gate states
  typedef enum logic [1:0] {
    VPC_R_IDLE = 2'b00,
    VPC_R_ARM = 2'b01,
    VPC_R_COUNT = 2'b10,
    VPC_R_CLOSE = 2'b11
  } vpc_ratio_state_t;
endpackage

//--- hdl/vpc_down_counter.sv
`timescale 1ns/1ps
`default_nettype none
module vpc_down_counter (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [15:0] load_value,
  input wire logic dec,
  output logic [15:0] count,
  output logic at_zero
);
  // load wins over a decrement in the same cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= vpc_pkg::CNT_MAX;
    end
    else if (clk_en)
    begin
      if (load)
      begin
        count <= load_value;
      end
      else if (dec)
      begin
        // natural wrap 0 -> max, counting carries on
        count <= count - vpc_pkg::CNT_ONE;
      end
    end
  end

  assign at_zero = (count == vpc_pkg::CNT_ZERO);
endmodule
`default_nettype wire

//--- hdl/vpc_pulse_counter.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - counters leave as two byte reads, low byte first, high byte second
// - cumulative counters never clear between reads
// - revolution and work counters wrap past zero and keep counting
// - interval timer one-shot, count 20480, timeout paces the reads
// - gate derives from the fixed reference, high for the chosen period
// - converter pulses count only while the gate is high
// - one second gate gives count equal to frequency in hertz
// - gated counter clears before the next gate period
// - unsynchronised gate allows plus or minus one count
// - ratiometric mode counts reference clocks over whole converter pulses
module vpc_pulse_counter #(
  parameter logic [15:0] TIMER_COUNT = vpc_pkg::TIMER_LOAD,
  parameter logic [31:0] GATE_CYCLES = 32'(vpc_pkg::GATE_CYCLES_CALC),
  parameter logic [31:0] RATIO_CYCLES = 32'(vpc_pkg::RATIO_CYCLES_CALC)
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic rev_pulse,
  input wire logic work_pulse,
  input wire logic rd_strobe,
  input wire logic [1:0] rd_sel,
  output logic [7:0] rd_data,
  input wire logic timer_trigger,
  output logic timer_done,
  input wire logic gate_enable,
  output logic gate_level,
  output logic [31:0] gated_count,
  output logic gated_valid,
  input wire logic ratio_start,
  output logic ratio_busy,
  output logic [15:0] ratio_pulses,
  output logic [31:0] ratio_ref_clocks,
  output logic ratio_valid
);
  // ==========================================
  // edge detection of converter and sensor pulses
  logic rev_prev;
  logic work_prev;
  logic rev_edge;
  logic work_edge;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rev_prev <= 1'b0;
      work_prev <= 1'b0;
    end
    else if (clk_en)
    begin
      rev_prev <= rev_pulse;
      work_prev <= work_pulse;
    end
  end

  assign rev_edge = rev_pulse & ~rev_prev;
  assign work_edge = work_pulse & ~work_prev;

  // ==========================================
  // cumulative counters and interval timer
  logic [15:0] cnt [vpc_pkg::NUM_RD];
  logic timer_zero;
  logic timer_run;

  // reset preloads max, so no clear is ever needed afterwards
  vpc_down_counter u_rev (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .load(1'b0),
    .load_value(vpc_pkg::CNT_MAX),
    .dec(rev_edge),
    .count(cnt[vpc_pkg::SEL_REV]),
    .at_zero()
  );

  vpc_down_counter u_work (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .load(1'b0),
    .load_value(vpc_pkg::CNT_MAX),
    .dec(work_edge),
    .count(cnt[vpc_pkg::SEL_WORK]),
    .at_zero()
  );

  vpc_down_counter u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .load(timer_trigger),
    .load_value(TIMER_COUNT),
    .dec(timer_run),
    .count(cnt[vpc_pkg::SEL_TIMER]),
    .at_zero(timer_zero)
  );

  // one-shot: low from trigger until the count runs out, retrigger restarts
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_run <= 1'b0;
      timer_done <= 1'b1;
    end
    else if (clk_en)
    begin
      if (timer_trigger)
      begin
        timer_run <= 1'b1;
        timer_done <= 1'b0;
      end
      else if (timer_run && cnt[vpc_pkg::SEL_TIMER] == vpc_pkg::CNT_ONE)
      begin
        timer_run <= 1'b0;
        timer_done <= 1'b1;
      end
    end
  end

  // ==========================================
  // byte reader: low byte read freezes the high byte for the next read
  logic [vpc_pkg::NUM_RD-1:0] hi_next;
  logic [7:0] hi_hold [vpc_pkg::NUM_RD];
  logic sel_ok;

  assign sel_ok = (rd_sel <= vpc_pkg::SEL_TIMER);

  genvar gi;
  generate
    for (gi = 0; gi < vpc_pkg::NUM_RD; gi++)
    begin : g_rd
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          hi_next[gi] <= 1'b0;
          hi_hold[gi] <= 8'h00;
        end
        else if (clk_en && rd_strobe && rd_sel == 2'(gi))
        begin
          hi_next[gi] <= ~hi_next[gi];
          if (!hi_next[gi])
          begin
            hi_hold[gi] <= cnt[gi][15:8];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data <= 8'h00;
    end
    else if (clk_en && rd_strobe)
    begin
      if (!sel_ok)
      begin
        rd_data <= 8'h00;
      end
      else if (hi_next[rd_sel])
      begin
        rd_data <= hi_hold[rd_sel];
      end
      else
      begin
        rd_data <= cnt[rd_sel][7:0];
      end
    end
  end

  // ==========================================
  // gated counting
  logic [31:0] gate_left;
  logic [31:0] gate_acc;
  logic gate_end;

  assign gate_end = gate_level && gate_left == vpc_pkg::WIDE_ONE;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_left <= vpc_pkg::WIDE_ZERO;
      gate_level <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!gate_enable || gate_end)
      begin
        // one low cycle between periods leaves room for the clear
        gate_level <= 1'b0;
        gate_left <= vpc_pkg::WIDE_ZERO;
      end
      else if (!gate_level)
      begin
        gate_level <= 1'b1;
        gate_left <= GATE_CYCLES;
      end
      else
      begin
        gate_left <= gate_left - vpc_pkg::WIDE_ONE;
      end
    end
  end

  // gate is free running against the pulses: result may be off by one
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_acc <= vpc_pkg::WIDE_ZERO;
      gated_count <= vpc_pkg::WIDE_ZERO;
      gated_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      gated_valid <= gate_end;
      if (gate_end)
      begin
        gated_count <= gate_acc + {31'h0000_0000, work_edge};
        gate_acc <= vpc_pkg::WIDE_ZERO;
      end
      else if (!gate_level || !gate_enable)
      begin
        // an aborted period must leave nothing behind for the next one
        gate_acc <= vpc_pkg::WIDE_ZERO;
      end
      else if (work_edge)
      begin
        gate_acc <= gate_acc + vpc_pkg::WIDE_ONE;
      end
    end
  end

  // ==========================================
  // ratiometric counting over whole converter periods
  vpc_pkg::vpc_ratio_state_t r_state;
  logic [31:0] r_left;
  logic [15:0] r_m;
  logic [31:0] r_n;

  assign ratio_busy = (r_state != vpc_pkg::VPC_R_IDLE);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_state <= vpc_pkg::VPC_R_IDLE;
      r_left <= vpc_pkg::WIDE_ZERO;
      r_m <= vpc_pkg::CNT_ZERO;
      r_n <= vpc_pkg::WIDE_ZERO;
      ratio_pulses <= vpc_pkg::CNT_ZERO;
      ratio_ref_clocks <= vpc_pkg::WIDE_ZERO;
      ratio_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      ratio_valid <= 1'b0;
      unique case (r_state)
        vpc_pkg::VPC_R_IDLE:
        begin
          if (ratio_start)
          begin
            r_state <= vpc_pkg::VPC_R_ARM;
          end
        end
        vpc_pkg::VPC_R_ARM:
        begin
          // window opens only on a converter edge
          if (work_edge)
          begin
            r_state <= vpc_pkg::VPC_R_COUNT;
            r_left <= RATIO_CYCLES;
            r_m <= vpc_pkg::CNT_ZERO;
            r_n <= vpc_pkg::WIDE_ONE;
          end
        end
        vpc_pkg::VPC_R_COUNT, vpc_pkg::VPC_R_CLOSE:
        begin
          if (work_edge)
          begin
            r_m <= r_m + vpc_pkg::CNT_ONE;
          end
          if (r_state == vpc_pkg::VPC_R_CLOSE && work_edge)
          begin
            // closes on a converter edge: m and n are both exact, n counts every cycle between the two edges
            r_state <= vpc_pkg::VPC_R_IDLE;
            ratio_pulses <= r_m + vpc_pkg::CNT_ONE;
            ratio_ref_clocks <= r_n;
            ratio_valid <= 1'b1;
          end
          else
          begin
            r_n <= r_n + vpc_pkg::WIDE_ONE;
            if (r_left == vpc_pkg::WIDE_ONE)
            begin
              r_state <= vpc_pkg::VPC_R_CLOSE;
            end
            if (r_left != vpc_pkg::WIDE_ZERO)
            begin
              r_left <= r_left - vpc_pkg::WIDE_ONE;
            end
          end
        end
      endcase
    end
  end

  // ==========================================
  // checks
  property p_rd_low;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && rd_strobe && rd_sel == vpc_pkg::SEL_REV && !hi_next[vpc_pkg::SEL_REV]
    |=> rd_data == $past(cnt[vpc_pkg::SEL_REV][7:0]) && hi_next[vpc_pkg::SEL_REV];
  endproperty
  a_rd_low: assert property (p_rd_low) else $error("low byte not returned first");

  property p_rd_high;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && rd_strobe && rd_sel == vpc_pkg::SEL_WORK && !hi_next[vpc_pkg::SEL_WORK]
    ##1 (clk_en && rd_strobe && rd_sel == vpc_pkg::SEL_WORK)
    |=> rd_data == $past(cnt[vpc_pkg::SEL_WORK][15:8], 2);
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("high byte not from low read");

  property p_no_clear;
    @(posedge core_clk) disable iff (!rst_n)
    !$stable(cnt[vpc_pkg::SEL_REV])
    |-> cnt[vpc_pkg::SEL_REV] == $past(cnt[vpc_pkg::SEL_REV]) - vpc_pkg::CNT_ONE;
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("revolution count jumped");

  property p_wrap;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && work_edge && cnt[vpc_pkg::SEL_WORK] == vpc_pkg::CNT_ZERO
    |=> cnt[vpc_pkg::SEL_WORK] == vpc_pkg::CNT_MAX;
  endproperty
  a_wrap: assert property (p_wrap) else $error("work counter did not wrap");

  property p_timer;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && timer_trigger
    |=> !timer_done && cnt[vpc_pkg::SEL_TIMER] == TIMER_COUNT;
  endproperty
  a_timer: assert property (p_timer) else $error("timer trigger not honoured");

  property p_timer_end;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && !timer_trigger && timer_run && cnt[vpc_pkg::SEL_TIMER] == vpc_pkg::CNT_ONE
    |=> timer_done && timer_zero;
  endproperty
  a_timer_end: assert property (p_timer_end) else $error("timeout not raised");

  property p_gate_ignore;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && !gate_level |=> gate_acc == vpc_pkg::WIDE_ZERO;
  endproperty
  a_gate_ignore: assert property (p_gate_ignore) else $error("count outside gate");

  property p_gate_clear;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && gate_end
    |=> gated_valid && gate_acc == vpc_pkg::WIDE_ZERO && !gate_level
        && gated_count == $past(gate_acc) + {31'h0000_0000, $past(work_edge)};
  endproperty
  a_gate_clear: assert property (p_gate_clear) else $error("gated result wrong");

  property p_gate_len;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && gate_enable && !gate_level && !$past(gate_level)
    |=> gate_level && gate_left == GATE_CYCLES;
  endproperty
  a_gate_len: assert property (p_gate_len) else $error("gate period not loaded");

  property p_ratio_close;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && r_state == vpc_pkg::VPC_R_CLOSE && work_edge
    |=> ratio_valid && ratio_ref_clocks == $past(r_n) && r_state == vpc_pkg::VPC_R_IDLE;
  endproperty
  a_ratio_close: assert property (p_ratio_close) else $error("ratio not closed on edge");
endmodule
`default_nettype wire

//--- test/vpc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module vpc_host_model (
  input wire logic core_clk,
  input wire logic [7:0] rd_data,
  output logic rd_strobe,
  output logic [1:0] rd_sel
);
  // ==========================================
  // reader state
  logic [31:0] rev_total;
  logic [15:0] rev_last;

  initial
  begin
    rd_strobe = 1'b0;
    rd_sel = 2'h0;
    rev_total = vpc_pkg::WIDE_ZERO;
    rev_last = vpc_pkg::CNT_ZERO;
  end

  // ==========================================
  // byte pair read, strobe held back to back across both bytes
  task automatic read_word(input logic [1:0] sel, output logic [15:0] word);
    @(negedge core_clk);
    rd_strobe = 1'b1;
    rd_sel = sel;
    @(negedge core_clk);
    word[7:0] = rd_data;
    @(negedge core_clk);
    word[15:8] = rd_data;
    rd_strobe = 1'b0;
  endtask

  task automatic read_up(input logic [1:0] sel, output logic [15:0] up);
    logic [15:0] raw;
    read_word(sel, raw);
    up = vpc_pkg::CNT_MAX - raw;
  endtask

  // ==========================================
  // running total; bench samples far more often than one wrap per read
  task automatic track_rev();
    logic [15:0] up;
    read_up(vpc_pkg::SEL_REV, up);
    // a reading below the last one means one wrap since then
    if (up < rev_last)
      rev_total = rev_total + 32'h0000_FFFF;
    rev_total = rev_total + {16'h0000, up} - {16'h0000, rev_last};
    rev_last = up;
  endtask
endmodule
`default_nettype wire

//--- test/vpc_pulse_counter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vpc_pulse_counter_tb;
  localparam logic [15:0] TC = 16'h0014;
  localparam logic [31:0] GC = 32'h0000_0032;
  localparam logic [31:0] RC = 32'h0000_0028;
  localparam int PER = 4;
  localparam logic [31:0] GX = GC / PER;
  logic core_clk, rst_n, clk_en, rev_pulse, work_pulse, work_run, rd_strobe;
  logic timer_trigger, timer_done, gate_enable, gate_level, gated_valid;
  logic ratio_start, ratio_busy, ratio_valid;
  logic [1:0] rd_sel;
  logic [7:0] rd_data;
  logic [15:0] ratio_pulses, word;
  logic [31:0] gated_count, ratio_ref_clocks;
  int err_total, tests_run, cycles, phase, work_seen;

  vpc_pulse_counter #(.TIMER_COUNT(TC), .GATE_CYCLES(GC), .RATIO_CYCLES(RC)) vpc_pulse_counter_i (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .rev_pulse(rev_pulse),
    .work_pulse(work_pulse), .rd_strobe(rd_strobe), .rd_sel(rd_sel), .rd_data(rd_data),
    .timer_trigger(timer_trigger), .timer_done(timer_done), .gate_enable(gate_enable),
    .gate_level(gate_level), .gated_count(gated_count), .gated_valid(gated_valid),
    .ratio_start(ratio_start), .ratio_busy(ratio_busy), .ratio_pulses(ratio_pulses),
    .ratio_ref_clocks(ratio_ref_clocks), .ratio_valid(ratio_valid)
  );

  vpc_host_model vpc_host_model_i (
    .core_clk(core_clk), .rd_data(rd_data), .rd_strobe(rd_strobe), .rd_sel(rd_sel)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ==========================================
  // converter pulse train, period PER cycles
  always @(negedge core_clk)
  begin
    phase <= work_run ? phase + 1 : 0;
    work_pulse <= work_run && (phase % PER >= PER / 2);
    // rising edges handed to the design, for the work counter check
    if (work_run && phase % PER == PER / 2)
      work_seen <= work_seen + 1;
  end

  // ==========================================
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic test_reads();
    vpc_host_model_i.read_word(vpc_pkg::SEL_REV, word);
    chk({16'h0000, word}, 32'h0000_FFFF);
    vpc_host_model_i.read_word(2'h3, word);
    chk({16'h0000, word}, 32'h0000_0000);
    repeat (5)
    begin
      @(negedge core_clk) rev_pulse = 1'b1;
      @(negedge core_clk) rev_pulse = 1'b0;
    end
    vpc_host_model_i.track_rev();
    chk(vpc_host_model_i.rev_total, 32'h0000_0005);
    repeat (3)
    begin
      @(negedge core_clk) rev_pulse = 1'b1;
      @(negedge core_clk) rev_pulse = 1'b0;
    end
    vpc_host_model_i.read_up(vpc_pkg::SEL_REV, word);
    chk({16'h0000, word}, 32'h0000_0008);
    // pulses while the clock enable is low must leave the total alone
    clk_en = 1'b0;
    repeat (2)
    begin
      @(negedge core_clk) rev_pulse = 1'b1;
      @(negedge core_clk) rev_pulse = 1'b0;
    end
    clk_en = 1'b1;
    vpc_host_model_i.read_up(vpc_pkg::SEL_REV, word);
    chk({16'h0000, word}, 32'h0000_0008);
  endtask

  task automatic test_timer();
    @(negedge core_clk) timer_trigger = 1'b1;
    @(negedge core_clk) timer_trigger = 1'b0;
    chk({31'h0, timer_done}, 32'h0);
    repeat (int'(TC) - 1) @(negedge core_clk);
    chk({31'h0, timer_done}, 32'h0);
    @(negedge core_clk);
    chk({31'h0, timer_done}, 32'h1);
    vpc_host_model_i.read_word(vpc_pkg::SEL_TIMER, word);
    chk({16'h0000, word}, 32'h0000_0000);
  endtask

  task automatic test_gated();
    int hi;
    work_run = 1'b1;
    gate_enable = 1'b1;
    for (int i = 0; i < 10 && gate_level !== 1'b1; i++) @(negedge core_clk);
    hi = 0;
    while (gate_level === 1'b1 && hi < 200)
    begin
      hi++;
      @(negedge core_clk);
    end
    chk(32'(hi), GC);
    chk({31'h0, gated_valid}, 32'h1);
    // ideal is GX plus one half: one count of slack each way leaves GX or GX + 1
    chk({31'h0, gated_count - GX <= 32'h0000_0001}, 32'h1);
    @(negedge core_clk);
    for (int i = 0; i < 200 && gated_valid !== 1'b1; i++) @(negedge core_clk);
    chk({31'h0, gated_count - GX <= 32'h0000_0001}, 32'h1);
    // abort part way through a period; the next full period must start from zero
    repeat (20) @(negedge core_clk);
    gate_enable = 1'b0;
    repeat (4) @(negedge core_clk);
    chk({31'h0, gate_level}, 32'h0);
    gate_enable = 1'b1;
    for (int i = 0; i < 200 && gated_valid !== 1'b1; i++) @(negedge core_clk);
    chk({31'h0, gated_valid}, 32'h1);
    chk({31'h0, gated_count - GX <= 32'h0000_0001}, 32'h1);
    gate_enable = 1'b0;
    work_run = 1'b0;
    repeat (4) @(negedge core_clk);
    chk({31'h0, gate_level}, 32'h0);
  endtask

  task automatic test_ratio();
    work_run = 1'b1;
    @(negedge core_clk) ratio_start = 1'b1;
    @(negedge core_clk) ratio_start = 1'b0;
    chk({31'h0, ratio_busy}, 32'h1);
    for (int i = 0; i < 300 && ratio_valid !== 1'b1; i++) @(negedge core_clk);
    chk({31'h0, ratio_valid}, 32'h1);
    // periodic input: reference clocks are exactly PER per whole pulse
    chk(ratio_ref_clocks, {16'h0000, ratio_pulses} * PER);
    chk({31'h0, ratio_ref_clocks >= RC}, 32'h1);
    // window closes on the first converter edge after RC cycles have run
    chk({16'h0000, ratio_pulses}, RC / PER + 32'h0000_0001);
    chk({31'h0, ratio_busy}, 32'h0);
    work_run = 1'b0;
  endtask

  task automatic test_work();
    repeat (4) @(negedge core_clk);
    vpc_host_model_i.read_up(vpc_pkg::SEL_WORK, word);
    chk({16'h0000, word}, work_seen & 32'h0000_FFFF);
  endtask

  initial
  begin
    rst_n = 1'b0;
    rev_pulse = 1'b0;
    work_run = 1'b0;
    work_pulse = 1'b0;
    phase = 0;
    timer_trigger = 1'b0;
    gate_enable = 1'b0;
    ratio_start = 1'b0;
    err_total = 0;
    tests_run = 0;
    cycles = 0;
    clk_en = 1'b1;
    work_seen = 0;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    test_reads();
    test_timer();
    test_gated();
    test_ratio();
    test_work();
    complete_run();
  end
endmodule
`default_nettype wire
